// [common/cwd_pkg.sv]
// package: constants for the watchdog with stop options
package cwd_pkg;
  localparam logic [15:0] SERVICE_ADDR   = 16'hFFFF;
  localparam int          PRE_W          = 12;
  localparam int          WD_W           = 6;
  localparam int          PRE_CLR_LSB    = 4;    // stage 5 is bit index 4
  localparam int          SHORT_TAP      = 7;    // short rate uses stage 7 carry
  localparam int          PIN_LOW_CYC    = 32;
  localparam int          REC_SHORT_CYC  = 32;
  localparam int          REC_LONG_CYC   = 4096;
  localparam int          POR_CLR_CYC    = 4096;
  localparam int          LONG_TIMEOUT   = 262128;
  localparam int          SHORT_TIMEOUT  = 8176;
  localparam logic [7:0]  VEC_LO_DEFAULT = 8'h00;   // arbitrary default
  localparam int          REC_W          = 13;

  typedef enum logic [1:0] {
    CWD_RUN  = 2'b00,
    CWD_STOP = 2'b01,
    CWD_REC  = 2'b11
  } cwd_mode_t;
endpackage

// [src/cwd_watchdog.sv]
// module: watchdog counter, stop/recovery control and reset pin driver
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
module cwd_watchdog (
  input  wire logic        clk,             // oscillator output clock, 50 MHz
  input  wire logic        rst_n,           // async internal reset, active low
  input  wire logic        por_n,           // power-on reset, active low
  input  wire logic [15:0] addr,            // cpu bus address
  input  wire logic [7:0]  wdata,           // cpu write data
  input  wire logic        wr,              // write strobe
  input  wire logic        rd,              // read strobe
  input  wire logic [7:0]  reset_vec_lo,    // low byte of stored reset vector
  input  wire logic        watchdog_disable,   // config option
  input  wire logic        watchdog_rate_sel,  // 1 short, 0 long timeout
  input  wire logic        stop_enable,        // stop instruction enable
  input  wire logic        short_recovery_sel, // 1 short stop recovery
  input  wire logic        pin_reset_enable_in,// config value to latch
  input  wire logic        pin_reset_enable_wr,// config write pulse
  input  wire logic        stop_exec,       // cpu executes stop opcode
  input  wire logic        stop_wake,       // wakeup request in stop
  input  wire logic        lvi_reset,       // low voltage inhibit reset
  input  wire logic        test_high_voltage, // monitor entry level on irq pin
  input  wire logic        break_active,    // break interrupt in progress
  input  wire logic        break_watchdog_disable, // bit of break_aux_reg
  output logic [7:0]       rdata,           // read data, cycle after rd
  output logic             wd_reset_req,    // one-cycle reset request
  output logic             reset_pin_out,   // reset pin output level
  output logic             reset_pin_oe,    // low while driving the pin
  output logic             wd_cause_flag,   // reset cause bit for reset_cause_reg
  output logic             illegal_opcode,  // stop taken as illegal opcode
  output logic             stop_active,     // in stop mode
  output logic             cpu_clk_run,     // low during stop and recovery
  output logic             pin_reset_enable // latched pin reset enable
);
  import cwd_pkg::*;

  logic [PRE_W-1:0] pre_q, pre_d;
  logic [WD_W-1:0]  wd_q, wd_d;
  logic             req_q, req_d;
  logic [5:0]       pin_q, pin_d;
  logic             flag_q, flag_d;
  logic             ill_q, ill_d;
  cwd_mode_t        mode_q, mode_d;
  logic [REC_W-1:0] rec_q, rec_d;
  logic             long_q, long_d;
  logic [7:0]       rdata_q, rdata_d;
  logic             pre_en_q, pre_en_d;
  logic [REC_W-1:0] por_q, por_d;
  logic             pren_q, pren_d;
  logic             oe_q, oe_d;
  logic             stop_q, stop_d;
  logic             crun_q, crun_d;

  logic svc_wr, wd_off, pre_carry, ovf, tick;

  function automatic logic hit(input logic [15:0] a);
    hit = (a == SERVICE_ADDR);
  endfunction

  assign svc_wr  = wr && hit(addr);
  assign wd_off  = watchdog_disable || test_high_voltage ||
                   (test_high_voltage && break_active && break_watchdog_disable);
  // short rate taps a low prescaler stage so 8176 = 2^13-16 matches 64*128-16
  assign pre_carry = watchdog_rate_sel ? (&pre_q[SHORT_TAP-1:0]) : (&pre_q);
  assign tick    = (mode_q != CWD_STOP) && pre_carry;
  assign ovf     = tick && (&wd_q) && !wd_off && !svc_wr;

  always_comb begin
    pre_d   = pre_q;
    wd_d    = wd_q;
    req_d   = 1'b0;
    pin_d   = pin_q;
    flag_d  = flag_q;
    ill_d   = 1'b0;
    mode_d  = mode_q;
    rec_d   = rec_q;
    long_d  = long_q;
    rdata_d = 8'h00;
    por_d   = por_q;
    pre_en_d = pre_en_q;
    pren_d  = pren_q;
    if (mode_q != CWD_STOP) begin
      pre_d = pre_q + PRE_W'(1);
    end
    if (tick) begin
      wd_d = wd_q + WD_W'(1);
    end
    if (!pre_en_q) begin
      por_d = por_q + REC_W'(1);
      if (por_q == REC_W'(POR_CLR_CYC - 1)) begin
        pre_d    = '0;
        pre_en_d = 1'b1;
      end
    end
    if (svc_wr) begin
      wd_d = '0;
      pre_d[PRE_W-1:PRE_CLR_LSB] = '0;
    end
    if (rd) begin
      rdata_d = hit(addr) ? reset_vec_lo : 8'h00;
    end
    if (ovf) begin
      req_d  = 1'b1;
      flag_d = 1'b1;
      wd_d   = '0;
      pre_d  = '0;
      if (pren_q) begin
        pin_d = 6'(PIN_LOW_CYC);
      end
    end else if (pin_q != 6'h00) begin
      pin_d = pin_q - 6'h01;
    end
    if (pin_reset_enable_wr) begin
      pren_d = pin_reset_enable_in;
    end
    unique case (mode_q)
      CWD_RUN: begin
        if (stop_exec && !stop_enable) begin
          ill_d = 1'b1;
        end else if (stop_exec) begin
          mode_d = CWD_STOP;
          pre_d  = '0;
        end
      end
      CWD_STOP: begin
        if (stop_wake || lvi_reset) begin
          mode_d = CWD_REC;
          long_d = lvi_reset || !short_recovery_sel;
          rec_d  = '0;
        end
      end
      CWD_REC: begin
        rec_d = rec_q + REC_W'(1);
        if (lvi_reset) begin
          long_d = 1'b1;
        end
        if (rec_q == (long_q ? REC_W'(REC_LONG_CYC - 1) : REC_W'(REC_SHORT_CYC - 1))) begin
          mode_d = CWD_RUN;
        end
      end
      default: mode_d = CWD_RUN;
    endcase
    // outputs are registered from next-state values so they keep the timing of the state itself
    oe_d   = (pin_d == 6'h00);
    stop_d = (mode_d == CWD_STOP);
    crun_d = (mode_d == CWD_RUN);
  end

  // internal reset clears both counters; the pin enable survives it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q    <= '0;
      wd_q     <= '0;
      req_q    <= 1'b0;
      pin_q    <= 6'h00;
      ill_q    <= 1'b0;
      mode_q   <= CWD_RUN;
      rec_q    <= '0;
      long_q   <= 1'b0;
      rdata_q  <= 8'h00;
      oe_q     <= 1'b1;
      stop_q   <= 1'b0;
      crun_q   <= 1'b1;
    end else begin
      pre_q    <= pre_d;
      wd_q     <= wd_d;
      req_q    <= req_d;
      pin_q    <= pin_d;
      ill_q    <= ill_d;
      mode_q   <= mode_d;
      rec_q    <= rec_d;
      long_q   <= long_d;
      rdata_q  <= rdata_d;
      oe_q     <= oe_d;
      stop_q   <= stop_d;
      crun_q   <= crun_d;
    end
  end

  // power-on-only state: cause flag is cleared by the reset controller's por
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      pren_q   <= 1'b0;
      flag_q   <= 1'b0;
      por_q    <= '0;
      pre_en_q <= 1'b0;
    end else begin
      pren_q   <= pren_d;
      flag_q   <= flag_d;
      por_q    <= por_d;
      pre_en_q <= pre_en_d;
    end
  end

  assign rdata            = rdata_q;
  assign wd_reset_req     = req_q;
  assign reset_pin_out    = 1'b0;
  // open-drain pin: the level is always low, the enable alone decides whether it is pulled
  assign reset_pin_oe     = oe_q;
  assign wd_cause_flag    = flag_q;
  assign illegal_opcode   = ill_q;
  assign stop_active      = stop_q;
  assign cpu_clk_run      = crun_q;
  assign pin_reset_enable = pren_q;

  // helpers: pulse and recovery lengths are counted here, apart from the design's own counters
  logic [6:0]       low_cnt_q;
  logic [REC_W-1:0] rec_cnt_q;
  logic             exp_long_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q  <= 7'h00;
      rec_cnt_q  <= '0;
      exp_long_q <= 1'b0;
    end else begin
      low_cnt_q  <= reset_pin_oe ? 7'h00 : low_cnt_q + 7'h01;
      rec_cnt_q  <= (mode_q == CWD_REC) ? rec_cnt_q + REC_W'(1) : '0;
      if (mode_q == CWD_STOP && (stop_wake || lvi_reset)) begin
        exp_long_q <= lvi_reset || !short_recovery_sel;
      end else if (mode_q == CWD_REC && lvi_reset) begin
        exp_long_q <= 1'b1;
      end
    end
  end

  chk_req_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");
  chk_disable_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    $past(watchdog_disable) |-> !wd_reset_req)
    else $error("reset while disabled");
  chk_monitor_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    $past(test_high_voltage) |-> !wd_reset_req)
    else $error("reset in monitor mode");
  chk_service_clears: assert property (@(posedge clk) disable iff (!rst_n)
    svc_wr |=> wd_q == '0 && pre_q[PRE_W-1:PRE_CLR_LSB] == '0)
    else $error("service did not clear");
  chk_stop_clears_pre: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == CWD_RUN && stop_exec && stop_enable) |=> pre_q == '0)
    else $error("stop left prescaler");
  chk_stop_freezes: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == CWD_STOP && $past(mode_q) == CWD_STOP) |-> $stable(wd_q))
    else $error("counter moved in stop");
  chk_illegal_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == CWD_RUN && stop_exec && !stop_enable) |=> illegal_opcode && !stop_active)
    else $error("stop not illegal");
  chk_read_vector: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && hit(addr)) |=> rdata == $past(reset_vec_lo))
    else $error("service read wrong");
  chk_pin_low_len: assert property (@(posedge clk) disable iff (!rst_n)
    (req_q && pren_q) |-> !reset_pin_oe [*8])
    else $error("pin released early");
  chk_cause_set: assert property (@(posedge clk) disable iff (!rst_n)
    wd_reset_req |-> wd_cause_flag)
    else $error("cause flag not set");
  chk_pin_low_total: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(reset_pin_oe) |-> low_cnt_q == 7'(PIN_LOW_CYC))
    else $error("reset pin low length wrong");
  chk_recovery_len: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == CWD_RUN && $past(mode_q) == CWD_REC) |->
    rec_cnt_q == (exp_long_q ? REC_W'(REC_LONG_CYC) : REC_W'(REC_SHORT_CYC)))
    else $error("stop recovery length wrong");
  chk_wake_leaves_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == CWD_STOP && (stop_wake || lvi_reset)) |=> !stop_active)
    else $error("wakeup did not leave stop");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_read_other: assert property (@(posedge clk) disable iff (!rst_n)
    (rd && !hit(addr)) |=> rdata == 8'h00)
    else $error("other address read not zero");
  chk_break_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    $past(test_high_voltage && break_active && break_watchdog_disable) |-> !wd_reset_req)
    else $error("reset during break");
  chk_ovf_full_count: assert property (@(posedge clk) disable iff (!rst_n)
    wd_reset_req |-> $past(tick && (&wd_q)))
    else $error("reset before counter overflow");
  chk_pre_counts: assert property (@(posedge clk) disable iff (!rst_n)
    (rst_n && mode_q != CWD_STOP && !svc_wr && !ovf && !stop_exec && pre_en_q) |=> pre_q == $past(pre_q) + PRE_W'(1))
    else $error("prescaler did not advance");
  chk_por_clears_pre: assert property (@(posedge clk) disable iff (!rst_n)
    (!pre_en_q && por_q == REC_W'(POR_CLR_CYC - 1)) |=> pre_q == '0)
    else $error("power-on prescaler clear missing");
  chk_no_pin_disabled: assert property (@(posedge clk) disable iff (!rst_n)
    (wd_reset_req && !pin_reset_enable) |-> reset_pin_oe)
    else $error("pin driven while its reset is off");
  chk_pin_enable_latch: assert property (@(posedge clk) disable iff (!por_n)
    pin_reset_enable_wr |=> pin_reset_enable == $past(pin_reset_enable_in))
    else $error("pin enable not latched");
  chk_cause_sticky: assert property (@(posedge clk) disable iff (!por_n)
    $past(wd_cause_flag) |-> wd_cause_flag)
    else $error("cause flag lost");
  chk_stop_no_pre: assert property (@(posedge clk) disable iff (!rst_n)
    (mode_q == CWD_STOP && $past(mode_q) == CWD_STOP && pre_en_q) |-> $stable(pre_q))
    else $error("prescaler moved in stop");

  cov_overflow: cover property (@(posedge clk) disable iff (!rst_n) wd_reset_req);
  cov_service: cover property (@(posedge clk) disable iff (!rst_n) svc_wr);
  cov_stop_exit: cover property (@(posedge clk) disable iff (!rst_n)
    mode_q == CWD_REC ##1 mode_q == CWD_RUN);
  cov_illegal: cover property (@(posedge clk) disable iff (!rst_n) illegal_opcode);
  cov_long_recovery: cover property (@(posedge clk) disable iff (!rst_n)
    mode_q == CWD_REC && exp_long_q);
endmodule

// [sim/cwd_cpu_model.sv]
// cpu bus side model: plain strobe bus master for the service location
`timescale 1ns/100ps
module cwd_cpu_model (
  input  wire logic        clk,    // oscillator clock
  output logic      [15:0] addr,   // bus address
  output logic      [7:0]  wdata,  // write data
  output logic             wr,     // write strobe
  output logic             rd,     // read strobe
  input  wire logic [7:0]  rdata   // read data, cycle after rd
);
  initial begin
    addr  = 16'h0000;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // one-cycle write; address inverted afterwards so a stale value never looks valid
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
  // service right after reset and around stop gives a full period
  task automatic service();
    bus_write(16'hFFFF, 8'h5A);
  endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the watchdog with stop options
`timescale 1ns/100ps
module testbench;
  import cwd_pkg::*;
  logic clk, rst_n, por_n, vdis, vrate, vstop, vsrec, pen_in, pen_wr, sexec, swake, low_voltage_inhibit, thv, brk, bwd;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, vec, d;
  logic        wr, rd, req, pin_out, pin_oe, cause, illegal, sact, crun, pen;
  int          fails = 0;
  int          tests_run = 0;
  int          n;
  cwd_cpu_model i_cwd_cpu_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  cwd_watchdog i_cwd_watchdog (.clk(clk), .rst_n(rst_n), .por_n(por_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .reset_vec_lo(vec), .watchdog_disable(vdis), .watchdog_rate_sel(vrate), .stop_enable(vstop),
    .short_recovery_sel(vsrec), .pin_reset_enable_in(pen_in), .pin_reset_enable_wr(pen_wr), .stop_exec(sexec),
    .stop_wake(swake), .lvi_reset(low_voltage_inhibit), .test_high_voltage(thv), .break_active(brk),
    .break_watchdog_disable(bwd), .rdata(rdata), .wd_reset_req(req), .reset_pin_out(pin_out),
    .reset_pin_oe(pin_oe), .wd_cause_flag(cause), .illegal_opcode(illegal), .stop_active(sact),
    .cpu_clk_run(crun), .pin_reset_enable(pen));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // count cycles until the reset request shows, up to lim
  task automatic wait_req(int lim);
    n = 0;
    while (req !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // count cycles until the cpu clock runs again, up to lim
  task automatic wait_run(int lim);
    n = 0;
    while (crun !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_read();
    i_cwd_cpu_model.bus_read(16'hFFFF, d);
    check("vector byte", 16'(vec), 16'(d));
    i_cwd_cpu_model.bus_read(16'hFFFE, d);
    check("other read", 16'h0000, 16'(d));
    $display("read test done");
  endtask
  task automatic t_stop();
    @(posedge clk) sexec <= 1'b1;
    @(posedge clk) sexec <= 1'b0;
    @(negedge clk) check("illegal stop", 16'h0001, 16'(illegal));
    check("no stop", 16'h0000, 16'(sact));
    vstop <= 1'b1;
    vsrec <= 1'b1;
    @(posedge clk) sexec <= 1'b1;
    @(posedge clk) sexec <= 1'b0;
    repeat (50) @(posedge clk);
    @(negedge clk);
    check("in stop", 16'h0001, 16'(sact));
    check("cpu clk off", 16'h0000, 16'(crun));
    check("no req in stop", 16'h0000, 16'(req));
    @(posedge clk) swake <= 1'b1;
    @(posedge clk) swake <= 1'b0;
    wait_run(100);
    check("short recovery", 16'(REC_SHORT_CYC + 1), 16'(n));
    i_cwd_cpu_model.service();
    @(posedge clk) sexec <= 1'b1;
    @(posedge clk) sexec <= 1'b0;
    repeat (20) @(posedge clk);
    low_voltage_inhibit <= 1'b1;
    @(posedge clk) low_voltage_inhibit <= 1'b0;
    wait_run(4200);
    check("lvi long recovery", 16'(REC_LONG_CYC + 1), 16'(n));
    i_cwd_cpu_model.service();
    $display("stop test done");
  endtask
  task automatic t_disable();
    for (int k = 0; k < 2; k++) begin
      vdis <= (k == 0);
      thv  <= (k == 1);
      i_cwd_cpu_model.service();
      wait_req(8400);
      check("disabled no reset", 16'h0000, 16'(req));
    end
    vdis <= 1'b0;
    thv  <= 1'b0;
    $display("disable test done");
  endtask
  task automatic t_timeout();
    check("flag clear", 16'h0000, 16'(cause));
    i_cwd_cpu_model.service();
    wait_req(8400);
    check("short timeout", 16'h0001, 16'(n >= 8144 && n <= 8208));
    check("pin low level", 16'h0000, 16'(pin_out));
    n = 0;
    while (pin_oe === 1'b0 && n < 64) begin
      @(negedge clk);
      n++;
      if (n == 1) check("req one cycle", 16'h0000, 16'(req));
    end
    check("pin low cycles", 16'(PIN_LOW_CYC), 16'(n));
    check("cause flag", 16'h0001, 16'(cause));
    vrate <= 1'b0;
    i_cwd_cpu_model.service();
    wait_req(8400);
    check("long rate quiet", 16'h0000, 16'(req));
    $display("timeout test done");
  endtask
  // internal reset mid-run: counters restart, power-on-only state survives
  task automatic t_reset();
    vrate <= 1'b1;
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    @(negedge clk);
    check("pin enable kept", 16'h0001, 16'(pen));
    check("cause flag kept", 16'h0001, 16'(cause));
    wait_req(8400);
    check("fresh period", 16'h0001, 16'(n >= 8180 && n <= 8200));
    $display("reset test done");
  endtask
  initial begin
    {rst_n, por_n, vdis, vstop, vsrec, pen_in, pen_wr, sexec, swake, low_voltage_inhibit, thv, brk, bwd} = '0;
    vrate = 1'b1;
    vec   = 8'hA7;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    // let the power-on prescaler clear pass so timeouts start clean
    repeat (4200) @(posedge clk);
    pen_in <= 1'b1;
    pen_wr <= 1'b1;
    @(posedge clk) pen_wr <= 1'b0;
    @(negedge clk) check("pin enable", 16'h0001, 16'(pen));
    i_cwd_cpu_model.service();
    t_read();
    t_stop();
    t_disable();
    t_timeout();
    t_reset();
    print_verdict();
  end
  initial begin
    #(70000 * 20);
    fails++;
    print_verdict();
  end
endmodule
